// File: crc_pkg.sv
// How it works
// - a comparator stays powered during sleep whenever its enable bit is set.
// - power-on reset loads comparator 2 control with all ones.
// - that all-ones state puts the comparator input pins in analog mode.
// - non power-on resets leave both comparator control registers untouched.
// - the reference offers 32 levels, 16 in a low and 16 in a high range.
// - range bit one gives level/24 of supply, zero gives 1/4 plus level/32.
// - the reference enable bit powers the generator, clear powers it down.
// - the pin drive bit overrides pin direction and drives the reference pin.
// - bit 4 of reference control reads as one and ignores writes.
// - the low four bits pick one of sixteen steps within the chosen range.
// - disabled, level zero and low range set gives ground as the reference.
// - the programmable reference feeds only comparator 2.
// - comparator 2 negative select one picks its pin, zero the reference.
// - in sleep, with wake enabled and a prior read latch, a change sets wake.
package crc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_CMP1_SMALL = 8'h07;
  localparam logic [7:0] ADDR_CMP1_LARGE = 8'h08;
  localparam logic [7:0] ADDR_CMP2 = 8'h0B;
  localparam logic [7:0] ADDR_REF = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h21;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h22;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CMP_POR_VAL = 8'hFF;
  localparam logic [7:0] REF_RST_VAL = 8'h3F;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CMP_OUT_BIT = 7;
  localparam int CMP_POL_BIT = 5;
  localparam int CMP_ON_BIT = 3;
  localparam int CMP_NSEL_BIT = 2;
  localparam int CMP_WAKE_DIS_BIT = 0;
  localparam int REF_PWR_BIT = 7;
  localparam int REF_PIN_BIT = 6;
  localparam int REF_LOW_BIT = 5;
  localparam int REF_UNUSED_BIT = 4;
  localparam int STAT_PIN_WAKE_BIT = 7;
  localparam int STAT_CMP_WAKE_BIT = 6;
  localparam int IRQ_WAKE_BIT = 0;
  localparam int IRQ_CHANGE_BIT = 1;
  // ---------------------------------------------------------------
  // reference ladder scaling, fractions of supply in 1/96 units
  // ---------------------------------------------------------------
  localparam int REF_LEVELS = 32;
  localparam int REF_STEPS = 16;
  localparam logic [6:0] REF_LOW_MUL = 7'h04;
  localparam logic [6:0] REF_HIGH_MUL = 7'h03;
  localparam logic [6:0] REF_HIGH_BASE = 7'h18;
endpackage : crc_pkg

// File: crc_ref_ladder.sv
`timescale 1ns/10ps
module crc_ref_ladder (
  // control fields
  input wire logic power_on,
  input wire logic low_range,
  input wire logic [3:0] level,
  // ratio of supply in 1/96 steps, and ground flag
  output logic [6:0] ratio,
  output logic at_ground
);
  localparam logic [6:0] REF_LOW_MUL_C = crc_pkg::REF_LOW_MUL;
  // low range: level/24 = 4*level/96; high: 24/96 + 3*level/96
  always_comb begin
    ratio = 7'h00;
    at_ground = 1'b0;
    if (low_range) begin
      ratio = 7'(REF_LOW_MUL_C * {3'h0, level});
    end else begin
      ratio = 7'(crc_pkg::REF_HIGH_BASE + crc_pkg::REF_HIGH_MUL * {3'h0, level});
    end
    if (!power_on) begin
      at_ground = low_range && (level == 4'h0);
      if (!at_ground) begin
        ratio = 7'h00;
      end
    end
  end
endmodule : crc_ref_ladder

// File: crc_top.sv
`timescale 1ns/10ps
module crc_top (
  // clock and resets
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic por_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // core state
  input wire logic sleep_mode,
  input wire logic pin_change_wake,
  // analog front end
  input wire logic cmp1_raw,
  input wire logic cmp2_raw,
  output logic cmp1_power,
  output logic cmp2_power,
  output logic cmp_pins_analog,
  output logic cmp2_neg_from_pin,
  output logic cmp2_neg_from_ref,
  // reference generator
  output logic ref_power,
  output logic ref_pin_override,
  output logic [6:0] ref_ratio,
  output logic ref_at_ground,
  // interrupt
  output logic irq
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] cmp1_reg;
  logic [7:0] cmp2_reg;
  logic [7:0] ref_reg;
  logic [1:0] out_latch_reg;
  logic latch_valid_reg;
  logic wake_flag_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_en_reg;
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] cmp_out;
  logic rd_cmp;
  logic wake_event;
  logic wake_clear;
  logic [1:0] irq_events;
  logic [1:0] irq_clear;
  logic [7:0] rdata_next;

  // ---------------------------------------------------------------
  // comparator outputs
  // ---------------------------------------------------------------
  // raw outputs are asynchronous analog results; two flops first
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
    end else begin
      s1_reg <= {cmp2_raw, cmp1_raw};
      s2_reg <= s1_reg;
    end
  end
  // polarity one means not inverted; off comparators read low
  assign cmp_out[0] = cmp1_reg[crc_pkg::CMP_ON_BIT] &
    ~(s2_reg[0] ^ cmp1_reg[crc_pkg::CMP_POL_BIT]) ;
  assign cmp_out[1] = cmp2_reg[crc_pkg::CMP_ON_BIT] &
    ~(s2_reg[1] ^ cmp2_reg[crc_pkg::CMP_POL_BIT]);

  // ---------------------------------------------------------------
  // comparator control registers
  // ---------------------------------------------------------------
  // only power-on reset touches these; sys_rst keeps them
  always_ff @(posedge mclk) begin
    if (por_rst) begin
      cmp1_reg <= crc_pkg::CMP_POR_VAL;
      cmp2_reg <= crc_pkg::CMP_POR_VAL;
    end else if (reg_wr) begin
      if (reg_addr == crc_pkg::ADDR_CMP1_SMALL || reg_addr == crc_pkg::ADDR_CMP1_LARGE) begin
        cmp1_reg <= reg_wdata;
      end else if (reg_addr == crc_pkg::ADDR_CMP2) begin
        cmp2_reg <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // reference control register
  // ---------------------------------------------------------------
  // this one reloads on every reset, unlike the comparators
  always_ff @(posedge mclk) begin
    if (sys_rst || por_rst) begin
      ref_reg <= crc_pkg::REF_RST_VAL;
    end else if (reg_wr && reg_addr == crc_pkg::ADDR_REF) begin
      ref_reg <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // wake-on-change
  // ---------------------------------------------------------------
  assign rd_cmp = reg_rd && (reg_addr == crc_pkg::ADDR_CMP1_SMALL ||
    reg_addr == crc_pkg::ADDR_CMP1_LARGE || reg_addr == crc_pkg::ADDR_CMP2);
  // a read snapshots outputs; change against snapshot during sleep wakes
  always_ff @(posedge mclk) begin
    if (sys_rst || por_rst) begin
      out_latch_reg <= 2'h0;
      latch_valid_reg <= 1'b0;
    end else if (rd_cmp) begin
      out_latch_reg <= cmp_out;
      latch_valid_reg <= 1'b1;
    end
  end
  // wake enable bits are active low
  assign wake_event = sleep_mode && latch_valid_reg && !rd_cmp &&
    (((cmp_out[0] ^ out_latch_reg[0]) && !cmp1_reg[crc_pkg::CMP_WAKE_DIS_BIT]) ||
     ((cmp_out[1] ^ out_latch_reg[1]) && !cmp2_reg[crc_pkg::CMP_WAKE_DIS_BIT]));
  assign wake_clear = reg_wr && reg_addr == crc_pkg::ADDR_STATUS &&
    !reg_wdata[crc_pkg::STAT_CMP_WAKE_BIT];
  // set beats clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst || por_rst) begin
      wake_flag_reg <= 1'b0;
    end else if (wake_event) begin
      wake_flag_reg <= 1'b1;
    end else if (wake_clear) begin
      wake_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, clear, enable
  // ---------------------------------------------------------------
  assign irq_events = {(rd_cmp ? 1'b0 : |(cmp_out ^ out_latch_reg)) & latch_valid_reg,
    wake_event};
  assign irq_clear = (reg_wr && reg_addr == crc_pkg::ADDR_IRQ_CLEAR) ? reg_wdata[1:0] : 2'h0;
  always_ff @(posedge mclk) begin
    if (sys_rst || por_rst) begin
      irq_stat_reg <= 2'h0;
    end else begin
      irq_stat_reg <= irq_events | (irq_stat_reg & ~irq_clear);
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || por_rst) begin
      irq_en_reg <= 2'h0;
    end else if (reg_wr && reg_addr == crc_pkg::ADDR_IRQ_ENABLE) begin
      irq_en_reg <= reg_wdata[1:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_en_reg);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr == crc_pkg::ADDR_STATUS) begin
      rdata_next[crc_pkg::STAT_PIN_WAKE_BIT] = pin_change_wake;
      rdata_next[crc_pkg::STAT_CMP_WAKE_BIT] = wake_flag_reg;
    end else if (reg_addr == crc_pkg::ADDR_CMP1_SMALL || reg_addr == crc_pkg::ADDR_CMP1_LARGE) begin
      rdata_next = {cmp_out[0], cmp1_reg[6:0]};
    end else if (reg_addr == crc_pkg::ADDR_CMP2) begin
      rdata_next = {cmp_out[1], cmp2_reg[6:0]};
    end else if (reg_addr == crc_pkg::ADDR_REF) begin
      rdata_next = ref_reg;
      rdata_next[crc_pkg::REF_UNUSED_BIT] = 1'b1;
    end else if (reg_addr == crc_pkg::ADDR_IRQ_STATUS) begin
      rdata_next = {6'h00, irq_stat_reg};
    end else if (reg_addr == crc_pkg::ADDR_IRQ_ENABLE) begin
      rdata_next = {6'h00, irq_en_reg};
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst || por_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // analog control outputs
  // ---------------------------------------------------------------
  // enable alone decides power, sleep does not gate it
  assign cmp1_power = cmp1_reg[crc_pkg::CMP_ON_BIT];
  assign cmp2_power = cmp2_reg[crc_pkg::CMP_ON_BIT];
  assign cmp_pins_analog = cmp2_reg == crc_pkg::CMP_POR_VAL ||
    cmp2_reg[crc_pkg::CMP_ON_BIT];
  assign cmp2_neg_from_pin = cmp2_reg[crc_pkg::CMP_NSEL_BIT];
  assign cmp2_neg_from_ref = ~cmp2_reg[crc_pkg::CMP_NSEL_BIT];
  assign ref_power = ref_reg[crc_pkg::REF_PWR_BIT];
  assign ref_pin_override = ref_reg[crc_pkg::REF_PIN_BIT];

  crc_ref_ladder u_ladder (
    .power_on(ref_reg[crc_pkg::REF_PWR_BIT]),
    .low_range(ref_reg[crc_pkg::REF_LOW_BIT]),
    .level(ref_reg[3:0]),
    .ratio(ref_ratio),
    .at_ground(ref_at_ground)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_por_load;
    @(posedge mclk) por_rst |=> cmp2_reg == 8'hFF && cmp1_reg == 8'hFF;
  endproperty
  a_por_load: assert property (p_por_load) else $error("por did not load ones");
  property p_keep;
    @(posedge mclk) (sys_rst && !por_rst && !reg_wr) |=> $stable(cmp2_reg) && $stable(cmp1_reg);
  endproperty
  a_keep: assert property (p_keep) else $error("sys reset changed comparators");
  property p_unused;
    @(posedge mclk) disable iff (sys_rst || por_rst)
      (reg_rd && reg_addr == crc_pkg::ADDR_REF) |=> reg_rdata[4];
  endproperty
  a_unused: assert property (p_unused) else $error("bit 4 read zero");
  property p_write;
    @(posedge mclk) disable iff (sys_rst || por_rst)
      (reg_wr && reg_addr == crc_pkg::ADDR_REF) |=> ref_power == $past(reg_wdata[7]);
  endproperty
  a_write: assert property (p_write) else $error("write not applied");
  property p_pin;
    @(posedge mclk) ref_pin_override == ref_reg[6];
  endproperty
  a_pin: assert property (p_pin) else $error("pin override wrong");
  property p_ground;
    @(posedge mclk) (!ref_power && ref_reg[5] && ref_reg[3:0] == 4'h0) |-> ref_at_ground;
  endproperty
  a_ground: assert property (p_ground) else $error("no ground output");
  property p_range;
    @(posedge mclk) (ref_power && !ref_reg[5]) |-> ref_ratio >= 7'h18;
  endproperty
  a_range: assert property (p_range) else $error("high range below quarter");
  property p_wake;
    @(posedge mclk) disable iff (sys_rst || por_rst) wake_event |=> wake_flag_reg;
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag not set");
  property p_sel;
    @(posedge mclk) cmp2_neg_from_ref != cmp2_neg_from_pin;
  endproperty
  a_sel: assert property (p_sel) else $error("negative select clash");

  // ---------------------------------------------------------------
  // control and reference checks
  // ---------------------------------------------------------------
  // any reset leaves the reference unpowered and off the pin
  property p_ref_rst;
    @(posedge mclk) (sys_rst || por_rst) |=> !ref_power && !ref_pin_override;
  endproperty
  a_ref_rst: assert property (p_ref_rst) else $error("reference not off after reset");
  // comparator 1 power follows its enable bit only
  property p_cmp1_pwr;
    @(posedge mclk) cmp1_power == cmp1_reg[crc_pkg::CMP_ON_BIT];
  endproperty
  a_cmp1_pwr: assert property (p_cmp1_pwr) else $error("cmp1 power mismatch");
  // comparator 2 power follows its enable bit only
  property p_cmp2_pwr;
    @(posedge mclk) cmp2_power == cmp2_reg[crc_pkg::CMP_ON_BIT];
  endproperty
  a_cmp2_pwr: assert property (p_cmp2_pwr) else $error("cmp2 power mismatch");
  // sleep must never cut comparator 2 while it is enabled
  property p_sleep_pwr;
    @(posedge mclk) (sleep_mode && cmp2_reg[crc_pkg::CMP_ON_BIT]) |-> cmp2_power;
  endproperty
  a_sleep_pwr: assert property (p_sleep_pwr) else $error("cmp2 off in sleep");
  // power-on state keeps the input pins analog
  property p_analog_por;
    @(posedge mclk) por_rst |=> cmp_pins_analog;
  endproperty
  a_analog_por: assert property (p_analog_por) else $error("pins digital after por");
  // negative select one routes the external pin
  property p_nsel_pin;
    @(posedge mclk) cmp2_neg_from_pin == cmp2_reg[crc_pkg::CMP_NSEL_BIT];
  endproperty
  a_nsel_pin: assert property (p_nsel_pin) else $error("negative pin select wrong");
  // reference reaches comparator 2 only when selected
  property p_ref_route;
    @(posedge mclk) cmp2_neg_from_ref |-> !cmp2_reg[crc_pkg::CMP_NSEL_BIT];
  endproperty
  a_ref_route: assert property (p_ref_route) else $error("reference routed wrongly");
  // low range is four ninety-sixths per step
  property p_low_ratio;
    @(posedge mclk) (ref_power && ref_reg[crc_pkg::REF_LOW_BIT]) |->
      ref_ratio == {1'b0, ref_reg[3:0], 2'b00};
  endproperty
  a_low_ratio: assert property (p_low_ratio) else $error("low range ratio wrong");
  // sixteen low steps top out at fifteen twenty-fourths
  property p_low_max;
    @(posedge mclk) (ref_power && ref_reg[crc_pkg::REF_LOW_BIT]) |-> ref_ratio <= 7'h3C;
  endproperty
  a_low_max: assert property (p_low_max) else $error("low range overrun");
  // high range tops out at a quarter plus fifteen thirty-seconds
  property p_high_max;
    @(posedge mclk) (ref_power && !ref_reg[crc_pkg::REF_LOW_BIT]) |-> ref_ratio <= 7'h45;
  endproperty
  a_high_max: assert property (p_high_max) else $error("high range overrun");
  // powered down and not grounded means no output at all
  property p_off_zero;
    @(posedge mclk) (!ref_power && !ref_at_ground) |-> ref_ratio == 7'h00;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("ratio while powered down");
  // ground output only exists with the generator off
  property p_gnd_off;
    @(posedge mclk) ref_at_ground |-> !ref_power;
  endproperty
  a_gnd_off: assert property (p_gnd_off) else $error("ground while powered");
  // power-on never drives the reference pin
  property p_pin_por;
    @(posedge mclk) por_rst |=> !ref_pin_override;
  endproperty
  a_pin_por: assert property (p_pin_por) else $error("pin driven after por");
  // control bits of comparator 2 read back as stored
  property p_rd_cmp2;
    @(posedge mclk) disable iff (sys_rst || por_rst)
      (reg_rd && reg_addr == crc_pkg::ADDR_CMP2) |=> reg_rdata[6:0] == $past(cmp2_reg[6:0]);
  endproperty
  a_rd_cmp2: assert property (p_rd_cmp2) else $error("cmp2 readback wrong");
  // comparator 2 write lands on the next edge, even in other resets
  property p_cmp2_wr;
    @(posedge mclk) disable iff (por_rst)
      (reg_wr && reg_addr == crc_pkg::ADDR_CMP2) |=> cmp2_reg == $past(reg_wdata);
  endproperty
  a_cmp2_wr: assert property (p_cmp2_wr) else $error("cmp2 write lost");
  // comparator 1 write through its second address
  property p_cmp1_wr;
    @(posedge mclk) disable iff (por_rst)
      (reg_wr && reg_addr == crc_pkg::ADDR_CMP1_LARGE) |=> cmp1_reg == $past(reg_wdata);
  endproperty
  a_cmp1_wr: assert property (p_cmp1_wr) else $error("cmp1 write lost");
  // the wake flag is sticky until software clears it
  property p_wake_hold;
    @(posedge mclk) disable iff (sys_rst || por_rst)
      (wake_flag_reg && !wake_clear) |=> wake_flag_reg;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake flag dropped");
  // an awake core never raises the wake flag
  property p_wake_awake;
    @(posedge mclk) disable iff (sys_rst || por_rst)
      (!wake_flag_reg && !sleep_mode) |=> !wake_flag_reg;
  endproperty
  a_wake_awake: assert property (p_wake_awake) else $error("wake flag while awake");
  // both wake enables off means no wake event
  property p_wake_dis;
    @(posedge mclk) (cmp1_reg[crc_pkg::CMP_WAKE_DIS_BIT] &&
      cmp2_reg[crc_pkg::CMP_WAKE_DIS_BIT]) |-> !wake_event;
  endproperty
  a_wake_dis: assert property (p_wake_dis) else $error("wake while disabled");
  // read data stands one cycle only, zero otherwise
  property p_rd_idle;
    @(posedge mclk) disable iff (sys_rst || por_rst) !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
endmodule : crc_top

// File: crc_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module crc_top_tb;
  // clock and resets
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_rst = 1'b1;
  // register port
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  // core state and analog inputs
  logic sleep_mode = 1'b0;
  logic pin_change_wake = 1'b0;
  logic cmp1_raw = 1'b0;
  logic cmp2_raw = 1'b0;
  // observed outputs
  logic cmp1_power, cmp2_power, cmp_pins_analog, cmp2_neg_from_pin, cmp2_neg_from_ref;
  logic ref_power, ref_pin_override, ref_at_ground, irq;
  logic [6:0] ref_ratio;
  int err_total = 0;
  int compares = 0;
  logic [7:0] rv;
  logic [6:0] e;

  crc_top dut (.mclk(mclk), .sys_rst(sys_rst), .por_rst(por_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_mode(sleep_mode), .pin_change_wake(pin_change_wake), .cmp1_raw(cmp1_raw),
    .cmp2_raw(cmp2_raw), .cmp1_power(cmp1_power), .cmp2_power(cmp2_power),
    .cmp_pins_analog(cmp_pins_analog), .cmp2_neg_from_pin(cmp2_neg_from_pin),
    .cmp2_neg_from_ref(cmp2_neg_from_ref), .ref_power(ref_power),
    .ref_pin_override(ref_pin_override), .ref_ratio(ref_ratio),
    .ref_at_ground(ref_at_ground), .irq(irq));

  // 25 MHz core clock
  always #20 mclk = ~mclk;

  // ---------------------------------------------------------------
  // register port tasks
  // ---------------------------------------------------------------
  // one-cycle write; the #1 lets the taking edge land before checks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] ex, input string nm);
    logic [7:0] d;
    rd(a, d);
    `CHK(nm, ex, d)
  endtask : rdchk

  task automatic finish_test();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  // whole run is under 1000 cycles, so 100 us means a hang
  initial begin
    #100000;
    err_total++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    #1;
    // power-on state: comparators all ones, raw inputs low give output 0
    rdchk(crc_pkg::ADDR_CMP1_SMALL, 8'h7F, "cmp1s_por");
    rdchk(crc_pkg::ADDR_CMP1_LARGE, 8'h7F, "cmp1l_por");
    rdchk(crc_pkg::ADDR_CMP2, 8'h7F, "cmp2_por");
    rdchk(crc_pkg::ADDR_REF, crc_pkg::REF_RST_VAL, "ref_por");
    `CHK("pins_analog", 1'b1, cmp_pins_analog)
    `CHK("neg_pin", 1'b1, cmp2_neg_from_pin)
    rdchk(8'h55, 8'h00, "unmapped");
    // every level in both ranges, bit 4 written zero must read one
    for (int i = 0; i < 32; i++) begin
      wr(crc_pkg::ADDR_REF, {2'b10, i[4], 1'b0, i[3:0]});
      e = 7'(i[4] ? 4 * i[3:0] : 24 + 3 * i[3:0]);
      `CHK("ratio", e, ref_ratio)
      `CHK("ref_pwr", 1'b1, ref_power)
      rdchk(crc_pkg::ADDR_REF, {2'b10, i[4], 1'b1, i[3:0]}, "ref_rb");
    end
    // disabled, low range, level zero gives ground; pin drive bit alone
    wr(crc_pkg::ADDR_REF, 8'h20);
    `CHK("gnd", 1'b1, ref_at_ground)
    `CHK("ref_off", 1'b0, ref_power)
    wr(crc_pkg::ADDR_REF, 8'h40);
    `CHK("pin_drv", 1'b1, ref_pin_override)
    // comparator 2 on, non-inverted, reference on negative input, wake on
    wr(crc_pkg::ADDR_CMP2, 8'h28);
    `CHK("neg_ref", 1'b1, cmp2_neg_from_ref)
    `CHK("neg_pin0", 1'b0, cmp2_neg_from_pin)
    rd(crc_pkg::ADDR_CMP2, rv);
    @(posedge mclk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("sleep_pwr", 1'b1, cmp2_power)
    @(posedge mclk);
    cmp2_raw <= 1'b1;
    pin_change_wake <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    `CHK("irq_masked", 1'b0, irq)
    rd(crc_pkg::ADDR_STATUS, rv);
    `CHK("wake_flag", 1'b1, rv[crc_pkg::STAT_CMP_WAKE_BIT])
    `CHK("pin_wake", 1'b1, rv[crc_pkg::STAT_PIN_WAKE_BIT])
    rd(crc_pkg::ADDR_IRQ_STATUS, rv);
    `CHK("irq_st", 1'b1, rv[crc_pkg::IRQ_WAKE_BIT])
    @(posedge mclk);
    sleep_mode <= 1'b0;
    wr(crc_pkg::ADDR_IRQ_ENABLE, 8'h01);
    `CHK("irq_on", 1'b1, irq)
    rd(crc_pkg::ADDR_CMP2, rv);
    wr(crc_pkg::ADDR_IRQ_CLEAR, 8'h01);
    `CHK("irq_clr", 1'b0, irq)
    wr(crc_pkg::ADDR_STATUS, 8'h00);
    rd(crc_pkg::ADDR_STATUS, rv);
    `CHK("wake_clr", 1'b0, rv[crc_pkg::STAT_CMP_WAKE_BIT])
    // other reset keeps comparator settings, restores the reference
    wr(crc_pkg::ADDR_CMP1_SMALL, 8'h00);
    wr(crc_pkg::ADDR_REF, 8'h8A);
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    rdchk(crc_pkg::ADDR_CMP1_SMALL, 8'h00, "cmp1_kept");
    rdchk(crc_pkg::ADDR_CMP2, 8'hA8, "cmp2_kept");
    rdchk(crc_pkg::ADDR_REF, crc_pkg::REF_RST_VAL, "ref_rst");
    `CHK("cmp1_off", 1'b0, cmp1_power)
    // power-on reset again loads all ones, output now high
    @(posedge mclk);
    por_rst <= 1'b1;
    @(posedge mclk);
    por_rst <= 1'b0;
    // power-on reset leaves the synchroniser as it was; two more cycles before the read
    repeat (2) @(posedge mclk);
    #1;
    rdchk(crc_pkg::ADDR_CMP2, 8'hFF, "cmp2_por2");
    `CHK("analog2", 1'b1, cmp_pins_analog)
    finish_test();
  end
endmodule : crc_top_tb
